// ---- verilog/scc_block.sv ----
// Purpose: four slice block: two carry columns of two slices, plus ram and
//          multiplier port sharing
// Assumes: configuration inputs are static during operation
// Notes:   carry datapath is combinational; sums also offered registered
// Notes on behaviour
// - low carry mux: select 1 carry, 0 generate
// - high carry mux: select 1 low mux, 0 generate
// - low select: table output or constant one
// - high select: table output or constant one
// - low sum is table xor incoming carry
// - high sum is table xor low mux
// - low product ands inputs one and two
// - high product ands inputs one and two
// - high generate picks input, product, bypass, constant
// - each slice computes two arithmetic bits
// - two tables, two flop-or-latch stores
// - memory slices: distributed_ram_sixteen or shift16 tables
// - four slices form two independent columns
// - wide ram mode blocks the multiplier
// - upper sixteen operand bits share ram data
`timescale 1ns/1ps
module scc_block (
   input  wire logic                       i_clk,
   input  wire logic                       i_reset_n,
   // per column carry in, per slice configuration (index = col*2+slice)
   input  wire logic [1:0]                 i_slice_carry_input,
   input  wire logic [3:0][3:0]            i_low_addr,
   input  wire logic [3:0][3:0]            i_high_addr,
   input  wire logic [3:0]                 i_upper_bypass_input,
   input  wire scc_pkg::scc_sel_src_t [3:0] i_sel_low_src,
   input  wire scc_pkg::scc_sel_src_t [3:0] i_sel_high_src,
   input  wire scc_pkg::scc_gen_src_t [3:0] i_gen_low_src,
   input  wire scc_pkg::scc_gen_src_t [3:0] i_gen_high_src,
   input  wire scc_pkg::scc_table_mode_t [3:0] i_table_mode,
   input  wire scc_pkg::scc_store_mode_t [3:0] i_store_mode,
   input  wire logic [3:0][15:0]           i_low_init,
   input  wire logic [3:0][15:0]           i_high_init,
   input  wire logic                       i_table_load,
   input  wire logic [3:0]                 i_table_we,
   input  wire logic [3:0]                 i_low_wdata,
   input  wire logic [3:0]                 i_high_wdata,
   input  wire logic [3:0]                 i_store_ce,
   // ram and multiplier sharing
   input  wire scc_pkg::scc_ram_width_t    i_ram_width,
   input  wire logic [17:0]                i_mult_operand_a,
   input  wire logic [17:0]                i_mult_operand_b,
   input  wire logic [35:0]                i_ram_wdata_a,
   input  wire logic [35:0]                i_ram_wdata_b,
   input  wire logic                       i_use_ram_route,
   // results
   output logic [3:0]                      o_sum_low,
   output logic [3:0]                      o_sum_high,
   output logic [3:0]                      o_sum_low_reg,
   output logic [3:0]                      o_sum_high_reg,
   output logic [1:0]                      o_slice_carry_output,
   output logic [3:0]                      o_carry_mux_low,
   output logic                            o_mult_available,
   output logic [17:0]                     o_mult_operand_a,
   output logic [17:0]                     o_mult_operand_b
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   // async assert, synchronous release through two stages
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic pick_gen(input scc_pkg::scc_gen_src_t src,
                                     input logic in_one, input logic in_two,
                                     input logic product, input logic bypass);
      unique case (src)
         scc_pkg::SCC_GEN_IN_ONE:  pick_gen = in_one;
         scc_pkg::SCC_GEN_IN_TWO:  pick_gen = in_two;
         scc_pkg::SCC_GEN_PRODUCT: pick_gen = product;
         scc_pkg::SCC_GEN_BYPASS:  pick_gen = bypass;
         scc_pkg::SCC_GEN_ONE:     pick_gen = 1'b1;
         default:                  pick_gen = 1'b0;  // zero and illegal codes
      endcase
   endfunction : pick_gen

   function automatic logic pick_sel(input scc_pkg::scc_sel_src_t src, input logic lut);
      pick_sel = (src == scc_pkg::SCC_SEL_ONE) ? 1'b1 : lut;
   endfunction : pick_sel

   // ------------------------------------------------------------
   // slice storage: tables and per slice carry logic
   // ------------------------------------------------------------
   logic [3:0] low_out;
   logic [3:0] high_out;
   logic [3:0] carry_select_low;
   logic [3:0] carry_select_high;
   logic [3:0] carry_generate_low;
   logic [3:0] carry_generate_high;
   logic [3:0] partial_product_low;
   logic [3:0] partial_product_high;
   logic [3:0] chain_carry_input;
   logic [3:0] carry_mux_low;
   logic [3:0] carry_mux_high;
   logic [3:0] sum_gate_low;
   logic [3:0] sum_gate_high;
   logic [3:0] low_q;
   logic [3:0] high_q;

   for (genvar s = 0; s < 4; s++) begin : g_slice
      // column zero is the memory capable pair; column one is logic only
      localparam logic MEM_CAP = (s < 2);

      scc_table u_low (
         .i_clk                  (i_clk),
         .i_rst_n                (rst_n),
         .i_memory_capable_slice (MEM_CAP),
         .i_mode                 (i_table_mode[s]),
         .i_init                 (i_low_init[s]),
         .i_load                 (i_table_load),
         .i_addr                 (i_low_addr[s]),
         .i_we                   (i_table_we[s]),
         .i_wdata                (i_low_wdata[s]),
         .o_out                  (low_out[s])
      );

      scc_table u_high (
         .i_clk                  (i_clk),
         .i_rst_n                (rst_n),
         .i_memory_capable_slice (MEM_CAP),
         .i_mode                 (i_table_mode[s]),
         .i_init                 (i_high_init[s]),
         .i_load                 (i_table_load),
         .i_addr                 (i_high_addr[s]),
         .i_we                   (i_table_we[s]),
         .i_wdata                (i_high_wdata[s]),
         .o_out                  (high_out[s])
      );

      // product gates on the first two table inputs
      assign partial_product_low[s]  = i_low_addr[s][0] & i_low_addr[s][1];
      assign partial_product_high[s] = i_high_addr[s][0] & i_high_addr[s][1];

      // generate selectors, fixed by configuration
      assign carry_generate_low[s]  = pick_gen(i_gen_low_src[s], i_low_addr[s][0],
                                       i_low_addr[s][1], partial_product_low[s],
                                       1'b0);
      assign carry_generate_high[s] = pick_gen(i_gen_high_src[s], i_high_addr[s][0],
                                       i_high_addr[s][1], partial_product_high[s],
                                       i_upper_bypass_input[s]);

      assign carry_select_low[s]  = pick_sel(i_sel_low_src[s], low_out[s]);
      assign carry_select_high[s] = pick_sel(i_sel_high_src[s], high_out[s]);

      // two carry stages per slice
      assign carry_mux_low[s]  = carry_select_low[s] ? chain_carry_input[s]
                                                     : carry_generate_low[s];
      assign carry_mux_high[s] = carry_select_high[s] ? carry_mux_low[s]
                                                      : carry_generate_high[s];

      // sums complete each of the two bits
      assign sum_gate_low[s]  = low_out[s] ^ chain_carry_input[s];
      assign sum_gate_high[s] = high_out[s] ^ carry_mux_low[s];

      scc_store u_store_low (
         .i_clk  (i_clk),
         .i_rst_n(rst_n),
         .i_mode (i_store_mode[s]),
         .i_ce   (i_store_ce[s]),
         .i_d    (sum_gate_low[s]),
         .o_q    (low_q[s])
      );

      scc_store u_store_high (
         .i_clk  (i_clk),
         .i_rst_n(rst_n),
         .i_mode (i_store_mode[s]),
         .i_ce   (i_store_ce[s]),
         .i_d    (sum_gate_high[s]),
         .o_q    (high_q[s])
      );
   end

   // ------------------------------------------------------------
   // column chaining
   // ------------------------------------------------------------
   // each column has its own chain; no carry crosses columns
   for (genvar c = 0; c < 2; c++) begin : g_col
      assign chain_carry_input[2*c]   = i_slice_carry_input[c];
      assign chain_carry_input[2*c+1] = carry_mux_high[2*c];
      assign o_slice_carry_output[c]  = carry_mux_high[2*c+1];
   end

   // combinational and registered sum outputs
   assign o_sum_low       = sum_gate_low;
   assign o_sum_high      = sum_gate_high;
   assign o_sum_low_reg   = low_q;
   assign o_sum_high_reg  = high_q;
   assign o_carry_mux_low = carry_mux_low;

   // ------------------------------------------------------------
   // ram and multiplier sharing
   // ------------------------------------------------------------
   // wide ram uses every shared wire, so the multiplier is lost
   assign o_mult_available = (i_ram_width != scc_pkg::SCC_RAM_WIDE);

   // shared upper sixteen bits: ram data drives them when routed so or in wide ram mode
   always_comb begin
      o_mult_operand_a = i_mult_operand_a;
      o_mult_operand_b = i_mult_operand_b;
      if (i_use_ram_route || !o_mult_available) begin
         o_mult_operand_a[17:2] = i_ram_wdata_a[35:20];
         o_mult_operand_b[17:2] = i_ram_wdata_b[35:20];
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   low_carry_mux_a: assert property (carry_mux_low[0] ==
      (carry_select_low[0] ? chain_carry_input[0] : carry_generate_low[0]))
      else $error("low carry mux wrong");

   high_carry_mux_a: assert property (!carry_select_high[1] |->
      carry_mux_high[1] == carry_generate_high[1])
      else $error("high carry mux wrong");

   low_select_one_a: assert property (i_sel_low_src[2] == scc_pkg::SCC_SEL_ONE |->
      carry_mux_low[2] == i_slice_carry_input[1])
      else $error("forced propagate failed");

   high_select_one_a: assert property (i_sel_high_src[0] == scc_pkg::SCC_SEL_ONE |->
      carry_mux_high[0] == carry_mux_low[0])
      else $error("high propagate failed");

   low_sum_a: assert property (o_sum_low[0] == (low_out[0] ^ i_slice_carry_input[0]))
      else $error("low sum wrong");

   high_sum_a: assert property (o_sum_high[1] == (high_out[1] ^ carry_mux_low[1]))
      else $error("high sum wrong");

   low_product_a: assert property (i_gen_low_src[0] == scc_pkg::SCC_GEN_PRODUCT |->
      carry_generate_low[0] == (i_low_addr[0][0] & i_low_addr[0][1]))
      else $error("low product wrong");

   bypass_gen_a: assert property (i_gen_high_src[3] == scc_pkg::SCC_GEN_BYPASS |->
      carry_generate_high[3] == i_upper_bypass_input[3])
      else $error("bypass generate wrong");

   store_flop_a: assert property (i_store_ce[0] && i_store_mode[0] ==
      scc_pkg::SCC_STORE_FLOP |=> o_sum_low_reg[0] == $past(sum_gate_low[0]))
      else $error("flop capture wrong");

   ripple_a: assert property (chain_carry_input[1] == carry_mux_high[0])
      else $error("ripple broken");

   mult_block_a: assert property (i_ram_width == scc_pkg::SCC_RAM_WIDE |->
      !o_mult_available && o_mult_operand_a[17:2] == i_ram_wdata_a[35:20])
      else $error("wide ram multiplier clash");

   // further slices and columns, so a wrong index cannot hide
   high_product_a: assert property (i_gen_high_src[1] == scc_pkg::SCC_GEN_PRODUCT |->
      carry_generate_high[1] == (i_high_addr[1][0] & i_high_addr[1][1]))
      else $error("high product wrong");

   low_select_table_a: assert property (i_sel_low_src[1] == scc_pkg::SCC_SEL_TABLE |->
      carry_select_low[1] == low_out[1])
      else $error("low select wrong");

   high_select_table_a: assert property (i_sel_high_src[2] == scc_pkg::SCC_SEL_TABLE |->
      carry_select_high[2] == high_out[2])
      else $error("high select wrong");

   high_gen_one_a: assert property (i_gen_high_src[0] == scc_pkg::SCC_GEN_ONE |->
      carry_generate_high[0])
      else $error("constant generate wrong");

   column_carry_a: assert property (chain_carry_input[3] == carry_mux_high[2] &&
      o_slice_carry_output[1] == carry_mux_high[3])
      else $error("column chain broken");

   mult_free_a: assert property (i_ram_width == scc_pkg::SCC_RAM_NARROW && !i_use_ram_route |->
      o_mult_available && o_mult_operand_b == i_mult_operand_b)
      else $error("multiplier operand lost");

   // main scenarios seen at least once
   carry_out_c:  cover property (o_slice_carry_output[0] && o_slice_carry_output[1]);
   wide_ram_c:   cover property (!o_mult_available);
   generate_c:   cover property (!carry_select_low[0] && carry_generate_low[0]);
   latch_mode_c: cover property (i_store_mode[1] == scc_pkg::SCC_STORE_LATCH && i_store_ce[1]);
   shift_mode_c: cover property (i_table_mode[0] == scc_pkg::SCC_TABLE_SHIFT && i_table_we[0]);

endmodule : scc_block

// ---- verilog/scc_pkg.sv ----
// Purpose: shared constants and types for the slice carry chain datapath
// Assumes: single 20 MHz clock, configuration held static on ports
// Notes:   depths and widths fixed, nothing is a parameter
package scc_pkg;

   // ------------------------------------------------------------
   // structure sizes
   // ------------------------------------------------------------
   localparam int unsigned TABLE_DEPTH   = 16;  // entries per lookup table
   localparam int unsigned TABLE_ADDR_W  = 4;
   localparam int unsigned SLICES_PER_COL = 2;  // slices stacked in one carry column
   localparam int unsigned COLUMNS       = 2;   // independent carry chains per block
   localparam int unsigned OPERAND_W     = 18;  // multiplier operand width
   localparam int unsigned SHARED_W      = 16;  // upper bits shared with ram data
   localparam int unsigned RAM_DATA_W    = 36;  // widest ram data word

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic       STORE_RESET   = 1'h0;
   localparam logic [15:0] TABLE_RESET  = 16'h0000;

   // ------------------------------------------------------------
   // configuration encodings
   // ------------------------------------------------------------
   typedef enum logic {
      SCC_SEL_TABLE,   // select from table output
      SCC_SEL_ONE      // constant one, always propagate
   } scc_sel_src_t;

   typedef enum logic [2:0] {
      SCC_GEN_IN_ONE,
      SCC_GEN_IN_TWO,
      SCC_GEN_PRODUCT,
      SCC_GEN_BYPASS,
      SCC_GEN_ONE,
      SCC_GEN_ZERO
   } scc_gen_src_t;

   typedef enum logic [1:0] {
      SCC_TABLE_LOGIC,
      SCC_TABLE_RAM,
      SCC_TABLE_SHIFT
   } scc_table_mode_t;

   typedef enum logic {
      SCC_STORE_FLOP,
      SCC_STORE_LATCH
   } scc_store_mode_t;

   typedef enum logic {
      SCC_RAM_NARROW,
      SCC_RAM_WIDE     // 512 deep, 36 bit words
   } scc_ram_width_t;

endpackage : scc_pkg

// ---- verilog/scc_table.sv ----
// Purpose: one 16 entry lookup table, usable as logic, ram or shift register
// Assumes: write and shift honoured only when the slice is memory capable
// Notes:   read data is combinational lookup, as a table must be
`timescale 1ns/1ps
module scc_table (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_memory_capable_slice,
   input  wire scc_pkg::scc_table_mode_t i_mode,
   input  wire logic [15:0]            i_init,
   input  wire logic                   i_load,
   input  wire logic [3:0]             i_addr,
   input  wire logic                   i_we,
   input  wire logic                   i_wdata,
   output logic                        o_out
);

   logic [15:0] contents;
   logic        mem_ok;

   assign mem_ok = i_memory_capable_slice && (i_mode != scc_pkg::SCC_TABLE_LOGIC);

   // contents: loaded by configuration, then written or shifted
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         contents <= scc_pkg::TABLE_RESET;
      end else if (i_load) begin
         contents <= i_init;
      end else if (mem_ok && i_we) begin
         if (i_mode == scc_pkg::SCC_TABLE_SHIFT) begin
            contents <= {contents[14:0], i_wdata};
         end else begin
            contents[i_addr] <= i_wdata;
         end
      end
   end

   // lookup; logic only slices never write, so act as pure functions
   assign o_out = contents[i_addr];

endmodule : scc_table

// ---- verilog/scc_store.sv ----
// Purpose: one slice storage element, flip-flop or latch behaviour
// Assumes: latch mode is emulated on the clock: transparent while gate high
// Notes:   a true latch is avoided so the design stays single clocked
`timescale 1ns/1ps
module scc_store (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_n,
   input  wire scc_pkg::scc_store_mode_t i_mode,
   input  wire logic                    i_ce,
   input  wire logic                    i_d,
   output logic                         o_q
);

   logic held;

   // edge capture with enable; latch mode tracks d while gate is open
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         held <= scc_pkg::STORE_RESET;
      end else if (i_ce) begin
         held <= i_d;
      end
   end

   // latch passes d straight through while open
   assign o_q = (i_mode == scc_pkg::SCC_STORE_LATCH && i_ce) ? i_d : held;

endmodule : scc_store

// ---- verification/scc_nbr_model.sv ----
// Purpose: neighbour slices above and below each carry column
// Assumes: previous slice hands over a settled carry level
// Notes:   the next slice samples on the clock, so it answers a cycle late
`timescale 1ns/1ps
module scc_nbr_model (
   input  wire logic       i_clk,
   input  wire logic [1:0] i_prev_carry,
   input  wire logic [1:0] i_slice_carry_output,
   output logic      [1:0] o_slice_carry_input,
   output logic      [1:0] o_next_carry
);
   // previous slice drives the chain carry straight in
   assign o_slice_carry_input = i_prev_carry;

   // next slice registers what leaves the column
   always_ff @(posedge i_clk) begin
      o_next_carry <= i_slice_carry_output;
   end
endmodule : scc_nbr_model

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the four slice carry block
// Assumes: inputs change at the falling edge, outputs checked mid-cycle
// Notes:   tables used as xor half-sum for adder runs, zero for generate runs
`timescale 1ns/1ps
module testbench;
   logic                          clk, rst_n, load, route;
   logic [1:0]                    prev_carry, slice_carry_input, slice_carry_output, next_carry;
   logic [3:0][3:0]               low_addr, high_addr;
   logic [3:0]                    bypass, we, lwd, hwd, ce, s_lo, s_hi, r_lo, r_hi, mux_lo;
   scc_pkg::scc_sel_src_t [3:0]   sel_lo, sel_hi;
   scc_pkg::scc_gen_src_t [3:0]   gen_lo, gen_hi;
   scc_pkg::scc_table_mode_t [3:0] tmode;
   scc_pkg::scc_store_mode_t [3:0] smode;
   scc_pkg::scc_ram_width_t       rwidth;
   logic [3:0][15:0]              linit, hinit;
   logic [17:0]                   opa, opb, mopa, mopb;
   logic [35:0]                   rda, rdb;
   logic                          avail;
   int                            err_count, num_checks;

   scc_nbr_model u_nbr (.i_clk(clk), .i_prev_carry(prev_carry), .i_slice_carry_output(slice_carry_output),
      .o_slice_carry_input(slice_carry_input), .o_next_carry(next_carry));

   scc_block u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_slice_carry_input(slice_carry_input),
      .i_low_addr(low_addr), .i_high_addr(high_addr), .i_upper_bypass_input(bypass),
      .i_sel_low_src(sel_lo), .i_sel_high_src(sel_hi), .i_gen_low_src(gen_lo),
      .i_gen_high_src(gen_hi), .i_table_mode(tmode), .i_store_mode(smode),
      .i_low_init(linit), .i_high_init(hinit), .i_table_load(load), .i_table_we(we),
      .i_low_wdata(lwd), .i_high_wdata(hwd), .i_store_ce(ce), .i_ram_width(rwidth),
      .i_mult_operand_a(opa), .i_mult_operand_b(opb), .i_ram_wdata_a(rda),
      .i_ram_wdata_b(rdb), .i_use_ram_route(route), .o_sum_low(s_lo), .o_sum_high(s_hi),
      .o_sum_low_reg(r_lo), .o_sum_high_reg(r_hi), .o_slice_carry_output(slice_carry_output),
      .o_carry_mux_low(mux_lo), .o_mult_available(avail), .o_mult_operand_a(mopa),
      .o_mult_operand_b(mopb));

   // ------------------------------------------------------------
   // clock and watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // generous: the tests need under two thousand cycles
   initial begin
      #(50 * 10000);
      err_count++;
      summarize();
   end

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic setup(input scc_pkg::scc_sel_src_t s, input scc_pkg::scc_gen_src_t g,
                        input scc_pkg::scc_table_mode_t m, input logic [15:0] v);
      @(negedge clk);
      for (int i = 0; i < 4; i++) begin
         sel_lo[i] = s;
         sel_hi[i] = s;
         gen_lo[i] = g;
         gen_hi[i] = g;
         tmode[i]  = m;
      end
      linit = {4{v}};
      hinit = {4{v}};
      load  = 1'b1;
      @(negedge clk);
      load = 1'b0;
   endtask : setup

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // two 4-bit adders, column one fed inverted operand and carry
   task automatic test_adder();
      logic [3:0] x, y, el, eh;
      logic [1:0] ec;
      logic [4:0] s;
      setup(scc_pkg::SCC_SEL_TABLE, scc_pkg::SCC_GEN_IN_ONE, scc_pkg::SCC_TABLE_LOGIC, 16'h6666);
      for (int a = 0; a < 16; a++) begin
         for (int b = 0; b < 16; b++) begin
            for (int c = 0; c < 2; c++) begin
               @(negedge clk);
               prev_carry = {~c[0], c[0]};
               for (int k = 0; k < 2; k++) begin
                  x = k ? ~a[3:0] : a[3:0];
                  y = b[3:0];
                  s = {1'b0, x} + {1'b0, y} + {4'h0, prev_carry[k]};
                  for (int j = 0; j < 2; j++) begin
                     low_addr[k*2+j]  = {2'(c), y[2*j], x[2*j]};
                     high_addr[k*2+j] = {2'(c), y[2*j+1], x[2*j+1]};
                     el[k*2+j] = s[2*j];
                     eh[k*2+j] = s[2*j+1];
                  end
                  ec[k] = s[4];
               end
               #5;
               chk({s_hi, s_lo, slice_carry_output}, {eh, el, ec});
            end
         end
      end
      $display("adder done");
   endtask : test_adder

   // constant-one selects pass the chain carry through both halves
   task automatic test_const_one();
      setup(scc_pkg::SCC_SEL_ONE, scc_pkg::SCC_GEN_ZERO, scc_pkg::SCC_TABLE_LOGIC, 16'h6666);
      low_addr  = {4{4'h3}};
      high_addr = {4{4'h3}};
      for (int c = 0; c < 4; c++) begin
         @(negedge clk);
         prev_carry = 2'(c);
         #5;
         chk(mux_lo, {{2{prev_carry[1]}}, {2{prev_carry[0]}}});
         chk(slice_carry_output, prev_carry);
         chk({s_hi, s_lo}, {2{{2{prev_carry[1]}}, {2{prev_carry[0]}}}});
         @(posedge clk);
         #1;
         chk(next_carry, prev_carry);
      end
      $display("const one done");
   endtask : test_const_one

   // every generate source, with the table at zero so generate wins
   task automatic test_gen();
      logic el, eh;
      for (int g = 0; g < 6; g++) begin
         setup(scc_pkg::SCC_SEL_TABLE, scc_pkg::scc_gen_src_t'(3'(g)),
               scc_pkg::SCC_TABLE_LOGIC, 16'h0000);
         for (int v = 0; v < 8; v++) begin
            @(negedge clk);
            prev_carry = 2'h3;
            low_addr  = {4{2'h0, v[1:0]}};
            high_addr = {4{2'h0, v[1:0]}};
            bypass    = {4{v[2]}};
            el = (g == 0) ? v[0] : (g == 1) ? v[1] : (g == 2) ? &v[1:0] : (g == 4);
            eh = (g == 3) ? v[2] : el;
            #5;
            chk(mux_lo, {4{el}});
            chk(slice_carry_output, {2{eh}});
            chk(s_hi, {4{el}});
         end
      end
      $display("generate done");
   endtask : test_gen

   // flop holds without enable, latch follows while enabled
   task automatic test_store();
      setup(scc_pkg::SCC_SEL_ONE, scc_pkg::SCC_GEN_ZERO, scc_pkg::SCC_TABLE_LOGIC, 16'h0000);
      prev_carry = 2'h3;
      ce = 4'hf;
      @(negedge clk);
      chk({r_hi, r_lo}, 8'hff);
      ce = 4'h0;
      prev_carry = 2'h0;
      @(negedge clk);
      chk({r_hi, r_lo}, 8'hff);
      smode = {4{scc_pkg::SCC_STORE_LATCH}};
      ce = 4'hf;
      #5;
      chk({r_hi, r_lo}, 8'h00);
      @(negedge clk);
      ce = 4'h0;
      prev_carry = 2'h3;
      @(negedge clk);
      chk({r_hi, r_lo}, 8'h00);
      smode = {4{scc_pkg::SCC_STORE_FLOP}};
      $display("store done");
   endtask : test_store

   // ram write and shift only land in memory-capable slices
   task automatic test_mem();
      prev_carry = 2'h0;
      setup(scc_pkg::SCC_SEL_ONE, scc_pkg::SCC_GEN_ZERO, scc_pkg::SCC_TABLE_RAM, 16'h0000);
      low_addr = {4{4'h5}};
      we  = 4'hf;
      lwd = 4'hf;
      hwd = 4'hf;
      @(negedge clk);
      we = 4'h0;
      #5;
      chk(s_lo, 4'h3);
      @(negedge clk);
      low_addr = {4{4'h4}};
      #5;
      chk(s_lo, 4'h0);
      setup(scc_pkg::SCC_SEL_ONE, scc_pkg::SCC_GEN_ZERO, scc_pkg::SCC_TABLE_SHIFT, 16'h0000);
      for (int n = 0; n < 3; n++) begin
         we  = 4'hf;
         lwd = (n == 0) ? 4'hf : 4'h0;
         hwd = lwd;
         @(negedge clk);
      end
      we = 4'h0;
      low_addr  = {4{4'h2}};
      high_addr = {4{4'h2}};
      #5;
      chk({s_hi, s_lo}, 8'h33);
      @(negedge clk);
      low_addr = {4{4'h0}};
      #5;
      chk(s_lo, 4'h0);
      $display("memory done");
   endtask : test_mem

   // narrow, wide and routed ram against the multiplier operands
   task automatic test_mult();
      for (int m = 0; m < 3; m++) begin
         @(negedge clk);
         opa = 18'h3fffe;
         opb = 18'h00001;
         rda = 36'h5a5a0_0000;
         rdb = 36'h3c3c0_0000;
         rwidth = (m == 1) ? scc_pkg::SCC_RAM_WIDE : scc_pkg::SCC_RAM_NARROW;
         route = (m == 2);
         #5;
         chk(avail, m != 1);
         if (m == 0) chk({mopa, mopb}, {opa, opb});
         else chk({mopa, mopb}, {rda[35:20], opa[1:0], rdb[35:20], opb[1:0]});
      end
      $display("mult done");
   endtask : test_mult

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {rst_n, load, route, prev_carry, low_addr, high_addr} = '0;
      {bypass, we, lwd, hwd, ce, linit, hinit, opa, opb, rda, rdb} = '0;
      sel_lo = '0;
      sel_hi = '0;
      gen_lo = '0;
      gen_hi = '0;
      tmode  = '0;
      smode  = '0;
      rwidth = scc_pkg::SCC_RAM_NARROW;
      err_count  = 0;
      num_checks = 0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk({r_hi, r_lo}, 8'h00);
      test_adder();
      test_const_one();
      test_gen();
      test_store();
      test_mem();
      test_mult();
      summarize();
   end
endmodule : testbench
